// ---- hdl/uartad_decode.sv ----
// serial port register address decoder with divisor latch access steering
//
// Local design decision: the plain strobed port.
`timescale 1ns/1ps

// What this block does
// R01 - data address: receive, transmit or divisor low
// R02 - latch bit set: data address hits divisor low
// R03 - divisor low also at its own address
// R04 - latch bit clear: receive on read, transmit write
// R05 - second address: interrupt enable or divisor high
// R06 - latch bit clear: second address hits interrupt enable
// R07 - latch bit set: second address hits divisor high
// R08 - divisor high also at its own address
// R09 - third address: identification read, queue control write
// R10 - sixteen-bit power control register, resets zero
// R11 - two fixed read-only identification words
// R12 - latch bit in line control, resets zero
module uartad_decode (
  // clock and reset
  input  wire logic                    i_core_clk,
  input  wire logic                    i_nrst,
  // register bus
  input  wire uartad_pkg::uartad_req_t  i_req,
  output logic [15:0]                   o_rdata,
  // serial core side
  input  wire uartad_pkg::uartad_stat_t i_stat,
  output uartad_pkg::uartad_evt_t       o_evt,
  output uartad_pkg::uartad_cfg_t       o_cfg
);
  import uartad_pkg::*;

  typedef struct packed {
    uartad_cfg_t cfg;
    logic [7:0]  scratch;
    logic [15:0] rdata;
    uartad_evt_t evt;
  } uartad_state_t;

  uartad_state_t state_reg;
  uartad_state_t state_next;

  logic latch;
  logic wr_data;
  logic wr_ier;
  logic rd_data;
  logic rd_ier;

  function automatic logic [15:0] uartad_byte16(input logic [7:0] b);
    uartad_byte16 = {8'h00, b};
  endfunction : uartad_byte16

  assign latch = state_reg.cfg.lcr[UARTAD_LCR_LATCH_BIT]; // R12

  // shared-address steering
  assign wr_data = i_req.wr && (i_req.addr == UARTAD_ADDR_DATA); // R01
  assign rd_data = i_req.rd && (i_req.addr == UARTAD_ADDR_DATA); // R01
  assign wr_ier  = i_req.wr && (i_req.addr == UARTAD_ADDR_IER); // R05
  assign rd_ier  = i_req.rd && (i_req.addr == UARTAD_ADDR_IER); // R05

  always_comb begin
    state_next     = state_reg;
    state_next.evt = '0;

    // writes
    if (wr_data) begin
      if (latch) begin
        state_next.cfg.div_lo = i_req.wdata[7:0]; // R02
      end else begin
        state_next.evt.tx_load = 1'b1; // R04
        state_next.evt.tx_byte = i_req.wdata[7:0]; // R04
      end
    end
    if (wr_ier) begin
      if (latch) begin
        state_next.cfg.div_hi = i_req.wdata[7:0]; // R07
      end else begin
        state_next.cfg.ier = i_req.wdata[7:0]; // R06
      end
    end
    if (i_req.wr) begin
      unique case (i_req.addr)
        UARTAD_ADDR_IIR: begin
          state_next.cfg.fcr      = i_req.wdata[7:0]; // R09
          state_next.evt.fcr_load = 1'b1; // R09
        end
        UARTAD_ADDR_LCR:    state_next.cfg.lcr    = i_req.wdata[7:0]; // R12
        UARTAD_ADDR_MCR:    state_next.cfg.mcr    = i_req.wdata[7:0];
        UARTAD_ADDR_SCR:    state_next.scratch    = i_req.wdata[7:0];
        UARTAD_ADDR_DIV_LO: state_next.cfg.div_lo = i_req.wdata[7:0]; // R03
        UARTAD_ADDR_DIV_HI: state_next.cfg.div_hi = i_req.wdata[7:0]; // R08
        UARTAD_ADDR_PECR:   state_next.cfg.pecr   = i_req.wdata; // R10
        default: begin
        end
      endcase
    end

    // reads: data stands only in the cycle after the strobe
    state_next.rdata = UARTAD_RST_RDATA;
    if (rd_data) begin
      if (latch) begin
        state_next.rdata = uartad_byte16(state_reg.cfg.div_lo); // R02
      end else begin
        state_next.rdata      = uartad_byte16(i_stat.rx_byte); // R04
        state_next.evt.rx_pop = 1'b1; // R04
      end
    end else if (rd_ier) begin
      state_next.rdata = latch ? uartad_byte16(state_reg.cfg.div_hi)
                               : uartad_byte16(state_reg.cfg.ier); // R06 R07
    end else if (i_req.rd) begin
      unique case (i_req.addr)
        UARTAD_ADDR_IIR: begin
          // reading identification may clear a pending source in the core
          state_next.rdata        = uartad_byte16(i_stat.iir); // R09
          state_next.evt.iir_read = 1'b1; // R09
        end
        UARTAD_ADDR_LCR:    state_next.rdata = uartad_byte16(state_reg.cfg.lcr);
        UARTAD_ADDR_MCR:    state_next.rdata = uartad_byte16(state_reg.cfg.mcr);
        UARTAD_ADDR_LSR:    state_next.rdata = uartad_byte16(i_stat.lsr);
        UARTAD_ADDR_SCR:    state_next.rdata = uartad_byte16(state_reg.scratch);
        UARTAD_ADDR_DIV_LO: state_next.rdata = uartad_byte16(state_reg.cfg.div_lo); // R03
        UARTAD_ADDR_DIV_HI: state_next.rdata = uartad_byte16(state_reg.cfg.div_hi); // R08
        UARTAD_ADDR_PID_LO: state_next.rdata = UARTAD_PID_LO_VAL; // R11
        UARTAD_ADDR_PID_HI: state_next.rdata = UARTAD_PID_HI_VAL; // R11
        UARTAD_ADDR_PECR:   state_next.rdata = state_reg.cfg.pecr; // R10
        default:            state_next.rdata = UARTAD_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg.cfg.ier    <= UARTAD_RST_IER;
      state_reg.cfg.fcr    <= UARTAD_RST_FCR;
      state_reg.cfg.lcr    <= UARTAD_RST_LCR; // R12
      state_reg.cfg.mcr    <= UARTAD_RST_MCR;
      state_reg.cfg.div_lo <= UARTAD_RST_BYTE;
      state_reg.cfg.div_hi <= UARTAD_RST_BYTE;
      state_reg.cfg.pecr   <= UARTAD_RST_PECR; // R10
      state_reg.scratch    <= UARTAD_RST_BYTE;
      state_reg.rdata      <= UARTAD_RST_RDATA;
      state_reg.evt        <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_rdata = state_reg.rdata;
  assign o_evt   = state_reg.evt;
  assign o_cfg   = state_reg.cfg;

endmodule : uartad_decode

// ---- hdl/uartad_pkg.sv ----
// package: register map, field positions and reset values for the serial port register decoder
package uartad_pkg;

  // word addresses
  localparam logic [15:0] UARTAD_ADDR_DATA      = 16'h9C00;
  localparam logic [15:0] UARTAD_ADDR_IER       = 16'h9C01;
  localparam logic [15:0] UARTAD_ADDR_IIR       = 16'h9C02;
  localparam logic [15:0] UARTAD_ADDR_LCR       = 16'h9C03;
  localparam logic [15:0] UARTAD_ADDR_MCR       = 16'h9C04;
  localparam logic [15:0] UARTAD_ADDR_LSR       = 16'h9C05;
  localparam logic [15:0] UARTAD_ADDR_SCR       = 16'h9C07;
  localparam logic [15:0] UARTAD_ADDR_DIV_LO    = 16'h9C08;
  localparam logic [15:0] UARTAD_ADDR_DIV_HI    = 16'h9C09;
  localparam logic [15:0] UARTAD_ADDR_PID_LO    = 16'h9C0A;
  localparam logic [15:0] UARTAD_ADDR_PID_HI    = 16'h9C0B;
  localparam logic [15:0] UARTAD_ADDR_PECR      = 16'h9C0C;

  // field positions
  localparam int          UARTAD_LCR_LATCH_BIT  = 7;

  // reset values
  localparam logic [7:0]  UARTAD_RST_IER        = 8'h00;
  localparam logic [7:0]  UARTAD_RST_IIR        = 8'h01;
  localparam logic [7:0]  UARTAD_RST_FCR        = 8'h00;
  localparam logic [7:0]  UARTAD_RST_LCR        = 8'h00;
  localparam logic [7:0]  UARTAD_RST_MCR        = 8'h00;
  localparam logic [7:0]  UARTAD_RST_LSR        = 8'h60;
  localparam logic [7:0]  UARTAD_RST_BYTE       = 8'h00;
  localparam logic [15:0] UARTAD_RST_PECR       = 16'h0000;
  localparam logic [15:0] UARTAD_RST_RDATA      = 16'h0000;

  // identification words: values are arbitrary
  localparam logic [15:0] UARTAD_PID_LO_VAL     = 16'h1234;
  localparam logic [15:0] UARTAD_PID_HI_VAL     = 16'h00A5;

  // register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } uartad_req_t;

  // strobes toward the serial core
  typedef struct packed {
    logic       tx_load;
    logic [7:0] tx_byte;
    logic       rx_pop;
    logic       fcr_load;
    logic       iir_read;
  } uartad_evt_t;

  // status from the serial core
  typedef struct packed {
    logic [7:0] rx_byte;
    logic [7:0] iir;
    logic [7:0] lsr;
  } uartad_stat_t;

  // configuration toward the serial core
  typedef struct packed {
    logic [7:0]  ier;
    logic [7:0]  fcr;
    logic [7:0]  lcr;
    logic [7:0]  mcr;
    logic [7:0]  div_lo;
    logic [7:0]  div_hi;
    logic [15:0] pecr;
  } uartad_cfg_t;

endpackage : uartad_pkg

// ---- verif/uartad_checker.sv ----
// assertions for the serial port register decoder
`timescale 1ns/1ps
module uartad_checker import uartad_pkg::*; (
  input wire logic         i_core_clk,
  input wire logic         i_nrst,
  input wire uartad_req_t  i_req,
  input wire logic [15:0]  o_rdata,
  input wire uartad_stat_t i_stat,
  input wire uartad_evt_t  o_evt,
  input wire uartad_cfg_t  o_cfg
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  wire       lb = o_cfg.lcr[UARTAD_LCR_LATCH_BIT];
  wire [7:0] d  = i_req.wdata[7:0];
  sequence wr_at(a, l); i_req.wr && i_req.addr == a && lb == l; endsequence
  sequence rd_at(a, l); i_req.rd && i_req.addr == a && lb == l; endsequence
  chk_tx_write: assert property (wr_at(UARTAD_ADDR_DATA, 0) |=> o_evt.tx_load && o_evt.tx_byte == $past(d))
    else $error("transmit load wrong");
  chk_rx_read: assert property (rd_at(UARTAD_ADDR_DATA, 0) |=>
    o_evt.rx_pop && o_rdata == {8'h00, $past(i_stat.rx_byte)})
    else $error("receive read wrong");
  chk_low_shared: assert property (wr_at(UARTAD_ADDR_DATA, 1) |=> !o_evt.tx_load && o_cfg.div_lo == $past(d))
    else $error("shared divisor low wrong");
  chk_ier_write: assert property (wr_at(UARTAD_ADDR_IER, 0) |=> o_cfg.ier == $past(d) && $stable(o_cfg.div_hi))
    else $error("interrupt enable write wrong");
  chk_high_shared: assert property (wr_at(UARTAD_ADDR_IER, 1) |=> o_cfg.div_hi == $past(d) && $stable(o_cfg.ier))
    else $error("shared divisor high wrong");
  chk_ident_read: assert property (i_req.rd && i_req.addr == UARTAD_ADDR_IIR |=>
    o_evt.iir_read && o_rdata == {8'h00, $past(i_stat.iir)})
    else $error("identification read wrong");
  chk_queue_write: assert property (i_req.wr && i_req.addr == UARTAD_ADDR_IIR |=>
    o_evt.fcr_load && o_cfg.fcr == $past(d))
    else $error("queue control write wrong");
  chk_low_direct: assert property (i_req.wr && i_req.addr == UARTAD_ADDR_DIV_LO |=> o_cfg.div_lo == $past(d))
    else $error("direct divisor low wrong");
  chk_high_direct: assert property (i_req.wr && i_req.addr == UARTAD_ADDR_DIV_HI |=> o_cfg.div_hi == $past(d))
    else $error("direct divisor high wrong");
endmodule : uartad_checker
bind uartad_decode uartad_checker uartad_checker_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_req(i_req),
  .o_rdata(o_rdata), .i_stat(i_stat), .o_evt(o_evt), .o_cfg(o_cfg));

// ---- verif/uartad_decode_test.sv ----
// self-checking bench for the serial port register decoder
`timescale 1ns/1ps
module uartad_decode_test;
  import uartad_pkg::*;
  logic         i_core_clk = 1'b0;
  logic         i_nrst = 1'b0;
  uartad_req_t  i_req = '0;
  uartad_stat_t i_stat = '0;
  logic [15:0]  o_rdata, pr, pecr;
  uartad_evt_t  o_evt, pe;
  uartad_cfg_t  o_cfg, pc;
  logic [7:0]   rg [16];
  integer       seed = 32'h9ABE, error_cnt = 0, checks_done = 0;
  uartad_decode uartad_decode_i (.i_core_clk(i_core_clk), .i_nrst(i_nrst), .i_req(i_req), .o_rdata(o_rdata),
    .i_stat(i_stat), .o_evt(o_evt), .o_cfg(o_cfg));
  initial forever #25 i_core_clk = ~i_core_clk;
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic give_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  task automatic clear;
    rg = '{default: 8'h00};
    {pr, pecr, pe, pc} = '0;
  endtask : clear
  // model keeps byte registers by low address nibble; the latch bit folds 0 and 1 onto 8 and 9
  task automatic step;
    uartad_req_t  q;
    uartad_stat_t s;
    logic [15:0]  er;
    logic [3:0]   k;
    er = 16'($random(seed) & 3);
    q = {16'h9C00 | 16'($random(seed) & 15), 16'($random(seed)), er == 16'h0000, er == 16'h0001};
    s = 24'($random(seed));
    k = q.addr[3:0];
    if (k < 4'h2 && pc.lcr[UARTAD_LCR_LATCH_BIT]) k += 4'h8;
    er = {8'h00, rg[k]};
    case (k)
      4'h0: er[7:0] = s.rx_byte;
      4'h2: er[7:0] = s.iir;
      4'h5: er[7:0] = s.lsr;
      4'hA: er = UARTAD_PID_LO_VAL;
      4'hB: er = UARTAD_PID_HI_VAL;
      4'hC: er = pecr;
      default: ;
    endcase
    if (!q.rd) er = '0;
    // read-only and unmapped places never take a write
    if (q.wr && k inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h7, 4'h8, 4'h9}) rg[k] = q.wdata[7:0];
    if (q.wr && k == 4'hC) pecr = q.wdata;
    @(posedge i_core_clk);
    i_req <= q;
    i_stat <= s;
    @(negedge i_core_clk);
    chk("rdata", 64'(o_rdata), 64'(pr));
    chk("events", 64'(o_evt & {1'h1, {8{pe.tx_load}}, 3'h7}), 64'(pe));
    chk("config", o_cfg, pc);
    pr = er;
    pe = {q.wr && k == 4'h0, q.wdata[7:0] & {8{q.wr && k == 4'h0}}, q.rd && k == 4'h0, q.wr && k == 4'h2,
      q.rd && k == 4'h2};
    pc = {rg[1], rg[2], rg[3], rg[4], rg[8], rg[9], pecr};
  endtask : step
  initial begin
    clear();
    repeat (16) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    repeat (1500) step();
    // second reset in mid-run: the last pending result is lost to it
    @(posedge i_core_clk);
    i_nrst <= 1'b0;
    i_req <= '0;
    clear();
    repeat (2) @(posedge i_core_clk);
    i_nrst <= 1'b1;
    repeat (1500) step();
    give_verdict();
  end
  initial begin
    #400000;
    error_cnt++;
    give_verdict();
  end
endmodule : uartad_decode_test
